// [shared/gamma_supervisor_map.vh]
`ifndef GAMMA_SUPERVISOR_MAP_VH
`define GAMMA_SUPERVISOR_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 6'h00
`define OFS_CAL_MAX 6'h04
`define OFS_SENS 6'h08
`define OFS_HOLD 6'h0c
`define OFS_STATUS 6'h10
`define OFS_GCOUNT 6'h14
`define OFS_GDUR 6'h18
`define OFS_CUR_CODE 6'h1c
`define OFS_CUR_TIME 6'h20
`define OFS_PREV_CODE 6'h24
`define OFS_PREV_TIME 6'h28
`define OFS_LIMIT 6'h2c
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_FAIL_HIGH 2
`define CTRL_G_DIAG_ALARM 3
`define CTRL_SCINT_LO 4
`define CTRL_SCINT_HI 5
// ----------------------------------------
// Status field positions
// ----------------------------------------
`define ST_GAMMA 0
`define ST_GAMMA_ALARM 1
`define ST_EXCESS 2
`define ST_HV_ON 3
`define ST_TEMP_WARN 4
`define ST_TEMP_ALARM 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL 6'h00
`define RST_CAL_MAX 20'h00000
`define RST_SENS 4'h3
`define RST_HOLD 16'h003c
// ----------------------------------------
// Detection modes and scintillator types
// ----------------------------------------
`define MODE_OFF 2'h0
`define MODE_ALARM 2'h1
`define MODE_WARN 2'h2
`define SCINT_IODIDE 2'h0
`define SCINT_PLASTIC 2'h1
`define SCINT_HT_PLASTIC 2'h2
// ----------------------------------------
// Loop currents in microamperes
// ----------------------------------------
`define LOOP_MINUS10 16'h0ed8
`define LOOP_FAIL_LOW 16'h0e10
`define LOOP_FAIL_HIGH 16'h53fc
// ----------------------------------------
// Process limits and diagnostic codes
// ----------------------------------------
`define RATE_MAX 20'h0fde8
`define EXCESS_SEC 1
`define PAUSE_SEC 16'h003c
`define SETTLE_SEC 16'h001e
`define CLK_HZ 20000000
`define DIAG_EXCESS 10'h39f
`define DIAG_GAMMA 10'h3bb
`define DIAG_TEMP 10'h33a
// ----------------------------------------
// Temperature thresholds in degrees C
// ----------------------------------------
`define T_HI80 9'sd80
`define T_HI65 9'sd65
`define T_HI60 9'sd60
`define T_LO40 -9'sd40
`define T_LO25 -9'sd25
`define T_LO20 -9'sd20
`endif

// [src/gamma_supervisor.v]
// Overview of operation
// - Gammagraphy declared when pulse rate rises above the limit.
// - Limit comes from calibration maximum and sensitivity setting.
// - Detection off: gammagraphy drives loop to 3.8 mA.
// - Alarm mode: gammagraphy drives loop to 3.6 or 21.5 mA.
// - Warning mode: loop holds last valid value before the event.
// - On entry the output freezes and a warning is raised.
// - Hold timer starts on detection; expiry applies the mode value.
// - Rate still above limit at expiry raises an alarm unless detection is off.
// - Gammagraphy log entry written only after the hold time.
// - Detection works only up to 65000 counts per second.
// - Condition end inside range returns at once to measuring.
// - Over range for 1 s raises excess diagnostic 927.
// - Excess alarm forces failure current unconditionally.
// - Excess alarm pauses high voltage 60 s, then rechecks.
// - After excess ends, readjust; alarm leaves about 30 s later.
// - Gammagraphy events counted and total duration accumulated.
// - Diagnostic 955 defaults to warning; behaviour is settable.
// - Sodium iodide: warning above +80 or below -40 C.
// - Plastic: alarm above +65, warning above +60 or below -40 C.
// - High-temp plastic: alarm below -25, warning >+80 or <-20 C.
// - Current and previous diagnostics kept with time stamps.
//
// The address map and register access over Avalon-MM were left to the implementer.
`include "gamma_supervisor_map.vh"
module gamma_supervisor #(
    parameter SEC_CYCLES = `CLK_HZ
) (
    input wire clk,
    input wire sys_rst,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire [19:0] pulse_rate,
    input wire [15:0] meas_ua,
    input wire signed [8:0] temp_c,
    output reg [15:0] loop_ua,
    output reg hv_enable,
    output reg warning_out,
    output reg alarm_out
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam G_IDLE = 2'h0;
    localparam G_HOLD = 2'h1;
    localparam G_EXPIRED = 2'h2;
    localparam E_NORM = 2'h0;
    localparam E_PAUSE = 2'h1;
    localparam E_CHECK = 2'h2;
    localparam E_SETTLE = 2'h3;
    localparam [31:0] EXCESS_FULL = SEC_CYCLES * `EXCESS_SEC - 1;
    localparam [31:0] SEC_FULL = SEC_CYCLES - 1;
    localparam [24:0] EXCESS_CYC = EXCESS_FULL[24:0];
    localparam [24:0] SEC_LAST = SEC_FULL[24:0];

    reg [5:0] ctrl;
    reg [19:0] cal_max;
    reg [3:0] sens;
    reg [15:0] hold_s;
    reg ack;
    reg [24:0] sec_cnt;
    reg sec_tick;
    reg [31:0] now_s;
    reg [1:0] g_state;
    reg [15:0] hold_cnt;
    reg [15:0] held_ua;
    reg [31:0] g_count;
    reg [31:0] g_dur;
    reg [1:0] e_state;
    reg [24:0] over_cnt;
    reg [15:0] e_cnt;
    reg temp_warn;
    reg temp_alarm;
    reg temp_prev;
    reg [9:0] cur_code;
    reg [31:0] cur_time;
    reg [9:0] prev_code;
    reg [31:0] prev_time;
    reg [15:0] next_loop;
    reg [31:0] rd_mux;

    wire [1:0] mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire [1:0] scint = ctrl[`CTRL_SCINT_HI:`CTRL_SCINT_LO];
    wire [15:0] fail_ua = ctrl[`CTRL_FAIL_HIGH] ? `LOOP_FAIL_HIGH
                                                : `LOOP_FAIL_LOW;
    wire wr_go = write & ack;

    // ----------------------------------------
    // Limit and range comparison
    // ----------------------------------------
    // Larger sensitivity widens the margin, so noise trips less often
    wire [23:0] margin = cal_max * sens;
    wire [20:0] limit = {1'b0, cal_max} + {4'h0, margin[23:7]};
    wire in_range = pulse_rate <= `RATE_MAX;
    wire over_limit = {1'b0, pulse_rate} > limit;
    wire gamma_now = over_limit & in_range;
    wire excess = e_state != E_NORM;
    wire hold_done = hold_cnt >= hold_s;
    wire g_expire = (g_state == G_HOLD) & gamma_now & hold_done;
    wire g_alarm = g_state == G_EXPIRED;
    wire excess_fire = (e_state == E_NORM) & ~in_range &
                       (over_cnt == EXCESS_CYC);
    wire temp_evt = (temp_warn | temp_alarm) & ~temp_prev;

    // ----------------------------------------
    // Avalon slave: one wait state per access
    // ----------------------------------------
    assign waitrequest = (read | write) & ~ack;

    // Ack rises one cycle after the request is seen
    always @(posedge clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    // Writable configuration
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `RST_CTRL;
            cal_max <= `RST_CAL_MAX;
            sens <= `RST_SENS;
            hold_s <= `RST_HOLD;
        end else if (wr_go) begin
            case (address)
                `OFS_CTRL: begin
                    ctrl <= writedata[5:0];
                end
                `OFS_CAL_MAX: begin
                    cal_max <= writedata[19:0];
                end
                `OFS_SENS: begin
                    sens <= writedata[3:0];
                end
                `OFS_HOLD: begin
                    hold_s <= writedata[15:0];
                end
                default: ctrl <= ctrl;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        case (address)
            `OFS_CTRL: rd_mux = {26'h0, ctrl};
            `OFS_CAL_MAX: rd_mux = {12'h0, cal_max};
            `OFS_SENS: rd_mux = {28'h0, sens};
            `OFS_HOLD: rd_mux = {16'h0, hold_s};
            `OFS_STATUS: rd_mux = {26'h0, temp_alarm, temp_warn,
                                   hv_enable, excess, g_alarm,
                                   g_state != G_IDLE};
            `OFS_GCOUNT: rd_mux = g_count;
            `OFS_GDUR: rd_mux = g_dur;
            `OFS_CUR_CODE: rd_mux = {22'h0, cur_code};
            `OFS_CUR_TIME: rd_mux = cur_time;
            `OFS_PREV_CODE: rd_mux = {22'h0, prev_code};
            `OFS_PREV_TIME: rd_mux = prev_time;
            `OFS_LIMIT: rd_mux = {11'h0, limit};
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data captured on the edge that raises ack
    always @(posedge clk) begin
        if (sys_rst) begin
            readdata <= 32'h0;
        end else if (read & ~ack) begin
            readdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Seconds time base and time stamp
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            sec_cnt <= 25'h0;
            sec_tick <= 1'b0;
            now_s <= 32'h0;
        end else begin
            sec_tick <= sec_cnt == SEC_LAST;
            if (sec_cnt == SEC_LAST) begin
                sec_cnt <= 25'h0;
                now_s <= now_s + 32'h1;
            end else begin
                sec_cnt <= sec_cnt + 25'h1;
            end
        end
    end

    // ----------------------------------------
    // Gammagraphy state machine
    // ----------------------------------------
    // Leaving the range hands control to the excess path instead
    always @(posedge clk) begin
        if (sys_rst) begin
            g_state <= G_IDLE;
            hold_cnt <= 16'h0;
            g_count <= 32'h0;
            g_dur <= 32'h0;
        end else begin
            case (g_state)
                G_IDLE: begin
                    hold_cnt <= 16'h0;
                    if (gamma_now) begin
                        g_state <= G_HOLD;
                        g_count <= g_count + 32'h1;
                    end
                end
                G_HOLD: begin
                    if (!gamma_now) begin
                        g_state <= G_IDLE;
                    end else if (hold_done) begin
                        g_state <= G_EXPIRED;
                    end else if (sec_tick) begin
                        hold_cnt <= hold_cnt + 16'h1;
                    end
                end
                G_EXPIRED: begin
                    if (!gamma_now) begin
                        g_state <= G_IDLE;
                    end
                end
                default: begin
                    g_state <= G_IDLE;
                end
            endcase
            if (g_state != G_IDLE && sec_tick) begin
                g_dur <= g_dur + 32'h1;
            end
        end
    end

    // Last valid value, frozen once gammagraphy begins
    always @(posedge clk) begin
        if (sys_rst) begin
            held_ua <= 16'h0;
        end else if (g_state == G_IDLE && !gamma_now && !excess) begin
            held_ua <= meas_ua;
        end
    end

    // ----------------------------------------
    // Excess radiation state machine
    // ----------------------------------------
    // Cycling the tube off protects it for arbitrarily long exposure
    always @(posedge clk) begin
        if (sys_rst) begin
            e_state <= E_NORM;
            over_cnt <= 25'h0;
            e_cnt <= 16'h0;
        end else begin
            if (in_range || excess) begin
                over_cnt <= 25'h0;
            end else begin
                over_cnt <= over_cnt + 25'h1;
            end
            case (e_state)
                E_NORM: begin
                    e_cnt <= 16'h0;
                    if (excess_fire) begin
                        e_state <= E_PAUSE;
                    end
                end
                E_PAUSE: begin
                    if (sec_tick && e_cnt == `PAUSE_SEC - 16'h1) begin
                        e_cnt <= 16'h0;
                        e_state <= E_CHECK;
                    end else if (sec_tick) begin
                        e_cnt <= e_cnt + 16'h1;
                    end
                end
                E_CHECK: begin
                    // One second with the tube back on to judge intensity
                    if (!in_range) begin
                        e_cnt <= 16'h0;
                        e_state <= E_PAUSE;
                    end else if (sec_tick) begin
                        e_state <= E_SETTLE;
                    end
                end
                E_SETTLE: begin
                    if (!in_range) begin
                        e_cnt <= 16'h0;
                        e_state <= E_PAUSE;
                    end else if (sec_tick &&
                                 e_cnt == `SETTLE_SEC - 16'h1) begin
                        e_state <= E_NORM;
                    end else if (sec_tick) begin
                        e_cnt <= e_cnt + 16'h1;
                    end
                end
                default: begin
                    e_state <= E_NORM;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Temperature diagnostic per scintillator
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            temp_warn <= 1'b0;
            temp_alarm <= 1'b0;
            temp_prev <= 1'b0;
        end else begin
            temp_prev <= temp_warn | temp_alarm;
            case (scint)
                `SCINT_IODIDE: begin
                    temp_alarm <= 1'b0;
                    temp_warn <= temp_c > `T_HI80 ||
                                 temp_c < `T_LO40;
                end
                `SCINT_PLASTIC: begin
                    temp_alarm <= temp_c > `T_HI65;
                    temp_warn <= temp_c > `T_HI60 ||
                                 temp_c < `T_LO40;
                end
                `SCINT_HT_PLASTIC: begin
                    temp_alarm <= temp_c < `T_LO25;
                    temp_warn <= temp_c > `T_HI80 ||
                                 temp_c < `T_LO20;
                end
                default: begin
                    temp_alarm <= 1'b0;
                    temp_warn <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Event log: current and previous entry
    // ----------------------------------------
    // Only one event per cycle is logged; excess takes priority
    always @(posedge clk) begin
        if (sys_rst) begin
            cur_code <= 10'h0;
            cur_time <= 32'h0;
            prev_code <= 10'h0;
            prev_time <= 32'h0;
        end else if (excess_fire || g_expire || temp_evt) begin
            prev_code <= cur_code;
            prev_time <= cur_time;
            cur_time <= now_s;
            if (excess_fire) begin
                cur_code <= `DIAG_EXCESS;
            end else if (g_expire) begin
                cur_code <= `DIAG_GAMMA;
            end else begin
                cur_code <= `DIAG_TEMP;
            end
        end
    end

    // ----------------------------------------
    // Loop output selection
    // ----------------------------------------
    always @* begin
        next_loop = meas_ua;
        if (excess) begin
            next_loop = fail_ua;
        end else if (g_state == G_HOLD) begin
            next_loop = held_ua;
        end else if (g_state == G_EXPIRED) begin
            case (mode)
                `MODE_OFF: next_loop = `LOOP_MINUS10;
                `MODE_ALARM: next_loop = fail_ua;
                default: next_loop = held_ua;
            endcase
        end
    end

    // Registered outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            loop_ua <= `LOOP_FAIL_LOW;
            hv_enable <= 1'b1;
            warning_out <= 1'b0;
            alarm_out <= 1'b0;
        end else begin
            loop_ua <= next_loop;
            hv_enable <= e_state != E_PAUSE;
            warning_out <= temp_warn | ((g_state != G_IDLE) &
                           ~ctrl[`CTRL_G_DIAG_ALARM]);
            alarm_out <= excess | temp_alarm | ((g_state != G_IDLE) &
                         ctrl[`CTRL_G_DIAG_ALARM]) |
                         (g_alarm & mode != `MODE_OFF);
        end
    end
endmodule

// [bench/gamma_supervisor_chk.sv]
`include "gamma_supervisor_map.vh"
module gamma_supervisor_chk #(
    parameter int SEC_CYCLES = 20
) (
    input wire clk,
    input wire sys_rst,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [19:0] pulse_rate,
    input wire [15:0] meas_ua,
    input wire signed [8:0] temp_c,
    input wire [15:0] loop_ua,
    input wire hv_enable,
    input wire warning_out,
    input wire alarm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Run lengths
    // ----------------------------------------
    int over_cnt;
    int off_cnt;
    logic [3:0] recent;
    wire fail_cur = loop_ua == `LOOP_FAIL_LOW || loop_ua == `LOOP_FAIL_HIGH;
    // Counters stand in for long repetitions the tools cannot unroll
    always @(posedge clk) begin
        if (sys_rst) begin
            over_cnt <= 0;
            off_cnt <= 0;
            recent <= 4'h0;
        end else begin
            over_cnt <= (pulse_rate > `RATE_MAX) ? over_cnt + 1 : 0;
            off_cnt <= hv_enable ? 0 : off_cnt + 1;
            recent <= {recent[2:0], pulse_rate > `RATE_MAX};
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_RESET_OUT: assert property ($fell(sys_rst) |-> loop_ua ==
        `LOOP_FAIL_LOW && hv_enable && !alarm_out && !warning_out)
        else $error("outputs not at reset values");
    AST_ONE_WAIT: assert property ($rose(read || write) |->
        waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait state");
    AST_UNMAPPED: assert property (read && !waitrequest &&
        address > `OFS_LIMIT |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_EXCESS_TRIP: assert property (over_cnt == SEC_CYCLES + 3 |->
        !hv_enable) else $error("over range did not trip");
    AST_EXCESS_CAUSE: assert property ($fell(hv_enable) |->
        recent != 4'h0) else $error("high voltage off without cause");
    AST_FAIL_CUR: assert property (!hv_enable [*2] |-> fail_cur)
        else $error("no failure current in pause");
    AST_PAUSE_MIN: assert property ($rose(hv_enable) |->
        off_cnt >= 59 * SEC_CYCLES) else $error("pause too short");
    AST_PAUSE_MAX: assert property (off_cnt <= 61 * SEC_CYCLES)
        else $error("pause too long");
    AST_SETTLE: assert property ($rose(hv_enable) |-> fail_cur [*8])
        else $error("alarm left before settling");
    cover property ($fell(hv_enable));
    cover property (loop_ua == `LOOP_MINUS10);
    cover property ($rose(alarm_out));
    cover property ($rose(warning_out));
endmodule

bind gamma_supervisor gamma_supervisor_chk #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pulse_rate(pulse_rate), .meas_ua(meas_ua),
    .temp_c(temp_c), .loop_ua(loop_ua), .hv_enable(hv_enable),
    .warning_out(warning_out), .alarm_out(alarm_out)
);

// [bench/detector_front_end.sv]
module detector_front_end (
    input wire clk,
    input wire [19:0] rate_set,
    input wire [15:0] meas_set,
    input wire signed [8:0] temp_set,
    output logic [19:0] pulse_rate,
    output logic [15:0] meas_ua,
    output logic signed [8:0] temp_c
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet detector at power up
    initial begin
        pulse_rate = 20'h0;
        meas_ua = 16'h0;
        temp_c = 9'sd20;
    end
    // Counting stage settles one cycle behind its target
    always @(posedge clk) begin
        pulse_rate <= rate_set;
        meas_ua <= meas_set;
        temp_c <= temp_set;
    end
endmodule

// [bench/tb_gamma_supervisor.sv]
`include "gamma_supervisor_map.vh"
module tb_gamma_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SEC = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0;
    logic [19:0] rate_set = 20'h0;
    logic [15:0] meas_set = 16'h2ee0;
    logic signed [8:0] temp_set = 9'sd20;
    wire [31:0] readdata;
    wire waitrequest;
    wire [19:0] pulse_rate;
    wire [15:0] meas_ua;
    wire [15:0] loop_ua;
    wire signed [8:0] temp_c;
    wire hv_enable;
    wire warning_out;
    wire alarm_out;
    int err_count = 0;
    int total_checks = 0;
    int seed = 32'hf5f0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [1:0] sc[8] = '{0, 0, 0, 1, 1, 2, 2, 2};
    logic signed [8:0] tv[8] = '{81, 80, -41, 61, 66, -21, -26, 81};
    logic [1:0] eb[8] = '{1, 0, 1, 1, 2, 1, 2, 1};
    logic [1:0] mk[8] = '{3, 3, 3, 3, 2, 3, 2, 3};

    gamma_supervisor #(.SEC_CYCLES(SEC)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pulse_rate(pulse_rate),
        .meas_ua(meas_ua), .temp_c(temp_c), .loop_ua(loop_ua),
        .hv_enable(hv_enable), .warning_out(warning_out),
        .alarm_out(alarm_out)
    );
    detector_front_end i_front (
        .clk(clk), .rate_set(rate_set), .meas_set(meas_set),
        .temp_set(temp_set), .pulse_rate(pulse_rate), .meas_ua(meas_ua),
        .temp_c(temp_c)
    );

    always #25 clk = ~clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] e);
        total_checks++;
        if (seen !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask
    // Request held until waitrequest is seen low, then a gap cycle
    task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [5:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(logic [5:0] a, logic [31:0] e,
                      logic [31:0] m = 32'hffffffff);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    // Bounded wait on the loop value or the high voltage flag
    task automatic wait_out(bit hv, logic [15:0] e, int maxc);
        int n;
        logic [15:0] v;
        n = 0;
        v = hv ? {15'h0, hv_enable} : loop_ua;
        while (v !== e && n < maxc) begin
            @(posedge clk);
            n++;
            v = hv ? {15'h0, hv_enable} : loop_ua;
        end
        check(hv ? "hv_enable" : "loop_ua", {16'h0, v}, {16'h0, e});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read answers are matched against the oldest note
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
            check("readdata", readdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [15:0] held;
        int s;
        int lim;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_SENS, 32'h3);
        rd(`OFS_HOLD, 32'h3c);
        rd(6'h30, 32'h0);
        wr(`OFS_STATUS, 32'hffffffff);
        rd(`OFS_STATUS, 32'h8);
        s = 1 + (($random(seed) & 32'hff) % 7);
        lim = 1000 + ((1000 * s) >> 7);
        wr(`OFS_CAL_MAX, 32'd1000);
        wr(`OFS_SENS, s);
        wr(`OFS_HOLD, 32'h2);
        rd(`OFS_LIMIT, lim);
        // Off, alarm with high failure current, warning with 955 as alarm
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTRL, (i == 1) ? 32'h5 : (i == 2) ? 32'ha : 32'h0);
            held = 16'h0fa0 + ($random(seed) & 16'h1fff);
            meas_set <= held;
            wait_out(0, held, 8);
            rate_set <= (i == 0) ? 20'd65000 : lim + 1;
            repeat (3) @(posedge clk);
            meas_set <= 16'h1000;
            repeat (3) @(posedge clk);
            wait_out(0, held, 1);
            check("warning_out", {31'h0, warning_out}, i != 2);
            check("alarm_out", {31'h0, alarm_out}, i == 2);
            rd(`OFS_CUR_CODE, (i == 0) ? 32'h0 : 32'h3bb);
            // The hold time of two seconds fixes this wait
            repeat (3 * SEC) @(posedge clk);
            wait_out(0, (i == 0) ? `LOOP_MINUS10 : (i == 1) ?
                     `LOOP_FAIL_HIGH : held, 1);
            check("alarm_out", {31'h0, alarm_out}, i != 0);
            rd(`OFS_STATUS, 32'h2, 32'h2);
            rd(`OFS_CUR_CODE, 32'h3bb);
            rd(`OFS_GCOUNT, i + 1);
            rate_set <= lim;
            wait_out(0, 16'h1000, 6);
        end
        // Excess radiation with low failure current
        wr(`OFS_CTRL, 32'h0);
        rate_set <= 20'd65001;
        wait_out(1, 16'h0, SEC + 10);
        wait_out(0, `LOOP_FAIL_LOW, 2);
        rd(`OFS_CUR_CODE, 32'h39f);
        rd(`OFS_PREV_CODE, 32'h3bb);
        repeat (30 * SEC) @(posedge clk);
        wait_out(1, 16'h0, 1);
        rate_set <= 20'h0;
        wait_out(1, 16'h1, 35 * SEC);
        repeat (20 * SEC) @(posedge clk);
        wait_out(0, `LOOP_FAIL_LOW, 1);
        wait_out(0, 16'h1000, 15 * SEC);
        // Temperature limits per scintillator type
        for (int k = 0; k < 8; k++) begin
            wr(`OFS_CTRL, {26'h0, sc[k], 4'h0});
            temp_set <= tv[k];
            repeat (4) @(posedge clk);
            rd(`OFS_STATUS, {26'h0, eb[k], 4'h0},
               {26'h0, mk[k], 4'h0});
        end
        rd(`OFS_CUR_CODE, 32'h33a);
        wrap_up();
    end
    // Hang guard sized well above the longest scenario
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule
